// >>> rtl/irbp_top.sv
// region assembly, flip geometry, binning and test-pattern pipeline
`timescale 1ns/100ps
`include "irbp_defs.svh"

module irbp_top
    import irbp_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire irbp_pix_s PIX_I,
    output irbp_pix_s PIX_O,
    output logic SENSOR_HFLIP,
    output logic SENSOR_VFLIP,
    output logic [15:0] SENSOR_LINE_FIRST,
    output logic [15:0] SENSOR_LINE_COUNT
);

    irbp_state_s s_q;
    irbp_state_s s_d;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // factor minus one, used as the last count of a bin group
    function automatic logic [1:0] bin_last(input irbp_bin_e b);
        case (b)
            BIN_2: bin_last = 2'd1;
            BIN_4: bin_last = 2'd3;
            default: bin_last = 2'd0;
        endcase
    endfunction

    function automatic logic [11:0] sat12(input logic [31:0] v);
        sat12 = (v > 32'(`IRBP_PIX_MAX)) ? `IRBP_PIX_MAX : v[11:0];
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            wmerge[8*b+:8] = sel[b] ? n[8*b+:8] : o[8*b+:8];
        end
    endfunction

    // reset image, including the sample region layout
    function automatic irbp_state_s init_state();
        irbp_state_s t;
        t = '0;
        t.hbin = BIN_1;
        t.vbin = BIN_1;
        t.pat = PAT_OFF;
        t.rows = `IRBP_DEF_ROWS;
        t.cols = `IRBP_DEF_COLS;
        t.sw = `IRBP_DEF_SW;
        t.sh = `IRBP_DEF_SH;
        t.hstep = `IRBP_DEF_STEP;
        t.vstep = `IRBP_DEF_STEP;
        for (int i = 0; i < 16; i++) begin
            t.ofs[i].x = 16'(i % `IRBP_GRID_DIM) * `IRBP_DEF_PITCH;
            t.ofs[i].y = 16'(i / `IRBP_GRID_DIM) * `IRBP_DEF_PITCH;
            t.siz[i].x = `IRBP_DEF_RW;
            t.siz[i].y = `IRBP_DEF_RH;
        end
        return t;
    endfunction

    // ****************************************************************
    // region geometry
    // ****************************************************************
    logic [15:0] cx;
    logic [15:0] cy;
    logic [15:0] ex [16];
    logic [15:0] ey [16];
    logic [15:0] rw [16];
    logic [15:0] rh [16];
    logic [15:0] hit;
    logic [15:0] ren;

    // current pixel position; a frame start forces the origin
    assign cx = PIX_I.sof ? 16'h0000 : s_q.x;
    assign cy = PIX_I.sof ? 16'h0000 : s_q.y;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_roi
            // shared sizes come from the row head and column head
            assign rw[gi] = s_q.siz[gi % 4].x;
            assign rh[gi] = s_q.siz[(gi / 4) * 4].y;
            assign ren[gi] = (3'(gi / 4) < s_q.rows) &&
                             (3'(gi % 4) < s_q.cols);
            // mirror inside the sensor so the same scene comes out
            assign ex[gi] = s_q.hflip ? s_q.sw - s_q.ofs[gi].x - rw[gi]
                                      : s_q.ofs[gi].x;
            assign ey[gi] = s_q.vflip ? s_q.sh - s_q.ofs[gi].y - rh[gi]
                                      : s_q.ofs[gi].y;
            assign hit[gi] = ren[gi] &&
                             cx >= ex[gi] && {1'b0, cx} < ex[gi] + rw[gi] &&
                             cy >= ey[gi] &&
                             {1'b0, cy} < ey[gi] + rh[gi];
        end
    endgenerate

    // ****************************************************************
    // read span and vertical bin qualification
    // ****************************************************************
    logic [15:0] span_first;
    logic [15:0] span_last;
    logic [15:0] tot_h;
    logic vb2_ok;
    logic vb4_ok;
    logic [1:0] hm;
    logic [1:0] vm;

    // lines from the top of the first to the bottom of the last region row are read out
    always_comb begin
        span_first = 16'hFFFF;
        span_last = 16'h0000;
        tot_h = 16'h0000;
        for (int r = 0; r < 4; r++) begin
            if (ren[r*4]) begin
                if (ey[r*4] < span_first) begin
                    span_first = ey[r*4];
                end
                if (ey[r*4] + rh[r*4] > span_last) begin
                    span_last = 16'(ey[r*4] + rh[r*4]);
                end
                tot_h = 16'(tot_h + rh[r*4]);
            end
        end
        if (!s_q.multi || span_first > span_last) begin
            span_first = 16'h0000;
            span_last = s_q.sh;
        end
        if (!s_q.multi) begin
            tot_h = s_q.sh;
        end
    end

    assign SENSOR_LINE_FIRST = span_first;
    assign SENSOR_LINE_COUNT = 16'(span_last - span_first);
    assign vb2_ok = ~tot_h[0];
    assign vb4_ok = (tot_h[1:0] == 2'b00);
    assign hm = bin_last(s_q.hbin);
    // a factor the height cannot honour is not offered
    assign vm = (s_q.vbin == BIN_4 && vb4_ok) ? 2'd3 :
                (s_q.vbin == BIN_2 && vb2_ok) ? 2'd1 : 2'd0;

    // ****************************************************************
    // test patterns
    // ****************************************************************
    logic [11:0] pat_h;
    logic [11:0] pat_v;
    logic [11:0] pat_d;
    logic [11:0] src;

    // ramps clip at full scale; the step sets how fast they get there
    // operands widened first so the sum cannot wrap before the clip
    assign pat_h = sat12(32'(cx) * 32'(s_q.hstep));
    assign pat_v = sat12(32'(cy) * 32'(s_q.vstep));
    assign pat_d = 12'(sat12(32'(pat_h) + 32'(pat_v)) + s_q.move);

    // pattern enters right at the sensor input, full depth
    always_comb begin
        case (s_q.pat)
            PAT_HRAMP: src = pat_h;
            PAT_VRAMP: src = pat_v;
            PAT_DIAG: src = pat_d;
            default: src = PIX_I.data;
        endcase
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [31:0] ctrl_w;
    logic [31:0] rd_word;
    logic [31:0] wv;
    logic req;

    assign req = WB_CYC_I & WB_STB_I;

    always_comb begin
        ctrl_w = '0;
        ctrl_w[`IRBP_CTRL_MULTI] = s_q.multi;
        ctrl_w[`IRBP_CTRL_HFLIP] = s_q.hflip;
        ctrl_w[`IRBP_CTRL_VFLIP] = s_q.vflip;
        ctrl_w[`IRBP_CTRL_HBIN] = s_q.hbin;
        ctrl_w[`IRBP_CTRL_VBIN] = s_q.vbin;
        ctrl_w[`IRBP_CTRL_PAT] = s_q.pat;
        ctrl_w[`IRBP_CTRL_FMT8] = s_q.fmt8;
    end

    // read mux; anything unmapped reads zero
    always_comb begin
        rd_word = '0;
        case (WB_ADR_I)
            `IRBP_REG_CTRL: rd_word = ctrl_w;
            `IRBP_REG_GRID: begin
                rd_word[`IRBP_GRID_ROWS] = s_q.rows;
                rd_word[`IRBP_GRID_COLS] = s_q.cols;
            end
            `IRBP_REG_SENS: rd_word = {s_q.sh, s_q.sw};
            `IRBP_REG_RAMP: rd_word = {4'h0, s_q.vstep, 4'h0, s_q.hstep};
            `IRBP_REG_STAT: rd_word = {s_q.frames, 14'h0000, vb4_ok, vb2_ok};
            `IRBP_REG_SPAN: rd_word = {SENSOR_LINE_COUNT, span_first};
            default: begin
                if (WB_ADR_I[1:0] == 2'b00) begin
                    if (WB_ADR_I[7:6] == `IRBP_BANK_OFS) begin
                        rd_word = s_q.ofs[WB_ADR_I[5:2]];
                    end else if (WB_ADR_I[7:6] == `IRBP_BANK_SIZ) begin
                        rd_word = s_q.siz[WB_ADR_I[5:2]];
                    end
                end
            end
        endcase
    end

    assign wv = wmerge(rd_word, WB_DAT_I, WB_SEL_I);

    // ****************************************************************
    // next state
    // ****************************************************************
    logic [15:0] hsum_n;
    logic [15:0] vacc;
    logic keep;

    assign keep = PIX_I.valid && (s_q.multi ? |hit : 1'b1);
    assign hsum_n = 16'((s_q.hcnt == 2'd0 ? 14'h0000 : s_q.hsum) + src);
    assign vacc = 16'((s_q.vcnt == 2'd0 ? 16'h0000 : s_q.lbuf[s_q.bx])
                      + hsum_n);

    always_comb begin
        s_d = s_q;
        // one wait state: ack the cycle after the request is seen
        s_d.ack = req & ~s_q.ack;
        if (req & ~s_q.ack) begin
            s_d.rdat = rd_word;
        end
        // writes land on the edge where the master sees ack
        if (req & s_q.ack & WB_WE_I) begin
            case (WB_ADR_I)
                `IRBP_REG_CTRL: begin
                    s_d.multi = wv[`IRBP_CTRL_MULTI];
                    s_d.hflip = wv[`IRBP_CTRL_HFLIP];
                    s_d.vflip = wv[`IRBP_CTRL_VFLIP];
                    s_d.hbin = irbp_bin_e'(wv[`IRBP_CTRL_HBIN]);
                    s_d.vbin = irbp_bin_e'(wv[`IRBP_CTRL_VBIN]);
                    s_d.pat = irbp_pat_e'(wv[`IRBP_CTRL_PAT]);
                    s_d.fmt8 = wv[`IRBP_CTRL_FMT8];
                end
                `IRBP_REG_GRID: begin
                    s_d.rows = wv[`IRBP_GRID_ROWS];
                    s_d.cols = wv[`IRBP_GRID_COLS];
                end
                `IRBP_REG_SENS: begin
                    s_d.sw = wv[15:0];
                    s_d.sh = wv[31:16];
                end
                `IRBP_REG_RAMP: begin
                    s_d.hstep = wv[11:0];
                    s_d.vstep = wv[27:16];
                end
                default: begin
                    if (WB_ADR_I[1:0] == 2'b00) begin
                        if (WB_ADR_I[7:6] == `IRBP_BANK_OFS) begin
                            s_d.ofs[WB_ADR_I[5:2]] = wv;
                        end else if (WB_ADR_I[7:6] == `IRBP_BANK_SIZ) begin
                            s_d.siz[WB_ADR_I[5:2]] = wv;
                        end
                    end
                end
            endcase
        end

        // output marks are single-cycle; input never waits
        s_d.out = '0;
        s_d.out.sof = PIX_I.valid & PIX_I.sof;
        if (PIX_I.valid) begin
            s_d.x = 16'(cx + 16'h0001);
            s_d.y = cy;
            s_d.lhit = s_q.lhit | keep;
            if (keep) begin
                // horizontal bin group, sums kept unclipped till the end
                if (s_q.hcnt == hm) begin
                    s_d.hcnt = 2'd0;
                    s_d.hsum = '0;
                    s_d.bx = 8'(s_q.bx + 8'h01);
                    // vertical group lives in the line store per column
                    if (s_q.vcnt == vm) begin
                        s_d.out.valid = 1'b1;
                        s_d.out.data = sat12(32'(vacc));
                        if (s_q.fmt8) begin
                            s_d.out.data = {4'h0, s_d.out.data[7:0]};
                        end
                    end else begin
                        s_d.lbuf[s_q.bx] = vacc;
                    end
                end else begin
                    s_d.hcnt = 2'(s_q.hcnt + 2'd1);
                    s_d.hsum = hsum_n[13:0];
                end
            end
            if (PIX_I.eol) begin
                // a partial horizontal group at line end is dropped
                s_d.x = '0;
                s_d.y = 16'(cy + 16'h0001);
                s_d.hcnt = '0;
                s_d.hsum = '0;
                s_d.bx = '0;
                s_d.lhit = 1'b0;
                if (s_q.lhit | keep) begin
                    if (s_q.vcnt == vm) begin
                        s_d.vcnt = '0;
                        s_d.out.eol = 1'b1;
                    end else begin
                        s_d.vcnt = 2'(s_q.vcnt + 2'd1);
                    end
                end
            end
            if (PIX_I.eof) begin
                s_d.y = '0;
                s_d.vcnt = '0;
                s_d.move = 12'(s_q.move + 12'h001);
                s_d.frames = 16'(s_q.frames + 16'h0001);
                s_d.out.eof = 1'b1;
            end
        end

        if (SYS_RST) begin
            s_d = init_state();
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge REF_CLK) begin
        s_q <= s_d;
    end

    assign WB_ACK_O = s_q.ack;
    assign WB_DAT_O = s_q.rdat;
    assign PIX_O = s_q.out;
    // readout order is reversed by the sensor, ahead of the patterns
    assign SENSOR_HFLIP = s_q.hflip;
    assign SENSOR_VFLIP = s_q.vflip;

endmodule

// >>> rtl/irbp_defs.svh
// constants for the region, flip, binning and test-pattern pipeline
`ifndef IRBP_DEFS_SVH
`define IRBP_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IRBP_REG_CTRL 8'h00
`define IRBP_REG_GRID 8'h04
`define IRBP_REG_SENS 8'h08
`define IRBP_REG_RAMP 8'h0C
`define IRBP_REG_STAT 8'h10
`define IRBP_REG_SPAN 8'h14
`define IRBP_BANK_OFS 2'b01
`define IRBP_BANK_SIZ 2'b10

// ****************************************************************
// field positions
// ****************************************************************
`define IRBP_CTRL_MULTI 0
`define IRBP_CTRL_HFLIP 1
`define IRBP_CTRL_VFLIP 2
`define IRBP_CTRL_HBIN 5:4
`define IRBP_CTRL_VBIN 7:6
`define IRBP_CTRL_PAT 9:8
`define IRBP_CTRL_FMT8 12
`define IRBP_GRID_ROWS 2:0
`define IRBP_GRID_COLS 10:8

// ****************************************************************
// reset values and limits
// ****************************************************************
`define IRBP_GRID_DIM 4
`define IRBP_DEF_ROWS 3'h4
`define IRBP_DEF_COLS 3'h4
`define IRBP_DEF_PITCH 16'h0080
`define IRBP_DEF_RW 16'h0040
`define IRBP_DEF_RH 16'h0040
`define IRBP_DEF_SW 16'h0280
`define IRBP_DEF_SH 16'h01E0
`define IRBP_DEF_STEP 12'h001
`define IRBP_PIX_MAX 12'hFFF

`endif

// >>> rtl/irbp_pkg.sv
// types shared by the pixel pipeline
package irbp_pkg;
    typedef enum logic [1:0] {BIN_1, BIN_2, BIN_4} irbp_bin_e;
    typedef enum logic [1:0] {PAT_OFF, PAT_HRAMP, PAT_VRAMP, PAT_DIAG} irbp_pat_e;

    // one pixel beat with its framing marks
    typedef struct packed {
        logic valid;
        logic sof;
        logic eol;
        logic eof;
        logic [11:0] data;
    } irbp_pix_s;

    // offset pair (y, x) or size pair (height, width)
    typedef struct packed {
        logic [15:0] y;
        logic [15:0] x;
    } irbp_roi_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic multi;
        logic hflip;
        logic vflip;
        irbp_bin_e hbin;
        irbp_bin_e vbin;
        irbp_pat_e pat;
        logic fmt8;
        logic [2:0] rows;
        logic [2:0] cols;
        logic [15:0] sw;
        logic [15:0] sh;
        logic [11:0] hstep;
        logic [11:0] vstep;
        irbp_roi_s [15:0] ofs;
        irbp_roi_s [15:0] siz;
        logic [15:0] x;
        logic [15:0] y;
        logic [11:0] move;
        logic [15:0] frames;
        logic [13:0] hsum;
        logic [1:0] hcnt;
        logic [7:0] bx;
        logic [1:0] vcnt;
        logic lhit;
        logic [255:0][15:0] lbuf;
        irbp_pix_s out;
    } irbp_state_s;
endpackage

// >>> dv/irbp_chk.sv
// concurrent checks on the pixel pipeline top ports
`timescale 1ns/100ps

module irbp_chk
    import irbp_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire irbp_pix_s PIX_I,
    input wire irbp_pix_s PIX_O,
    input wire logic SENSOR_HFLIP,
    input wire logic SENSOR_VFLIP
);
    // ****************************************
    // control shadow
    // ****************************************
    logic [12:0] ctrl_q;
    logic wr0;
    logic pass;
    // completed control write; bench always writes all bytes
    assign wr0 = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O
        && WB_ADR_I == 8'h00;
    assign pass = (ctrl_q & 13'h13F1) == 13'h0000;

    // shadow lets stream checks know the live mode
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            ctrl_q <= 13'h0000;
        end else if (wr0) begin
            ctrl_q <= WB_DAT_I[12:0];
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_ack_one;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("late ack");
    property p_ack_drop;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("long ack");
    // flips leave on the sensor pins, one settle cycle allowed
    property p_flip;
        !wr0 && !$past(wr0) |->
            SENSOR_HFLIP == ctrl_q[1] && SENSOR_VFLIP == ctrl_q[2];
    endproperty
    a_flip: assert property (p_flip) else $error("flip pins");
    property p_pass;
        pass && PIX_I.valid |=>
            PIX_O.valid && PIX_O.data == $past(PIX_I.data);
    endproperty
    a_pass: assert property (p_pass) else $error("pass beat");
    property p_sof;
        PIX_I.valid && PIX_I.sof |=> PIX_O.sof;
    endproperty
    a_sof: assert property (p_sof) else $error("sof lost");
    property p_eof;
        PIX_I.valid && PIX_I.eof |=> PIX_O.eof;
    endproperty
    a_eof: assert property (p_eof) else $error("eof lost");
    property p_fmt8;
        ctrl_q[12] && PIX_O.valid |-> PIX_O.data[11:8] == 4'h0;
    endproperty
    a_fmt8: assert property (p_fmt8) else $error("wide data");
    property p_cause;
        PIX_O.valid |-> $past(PIX_I.valid);
    endproperty
    a_cause: assert property (p_cause) else $error("no cause");
    property p_hbin;
        ctrl_q[5:4] != 2'b00 && PIX_O.valid |=> !PIX_O.valid;
    endproperty
    a_hbin: assert property (p_hbin) else $error("bin rate");

    c_pass: cover property (pass && PIX_I.valid);
    c_bin4: cover property (ctrl_q[5:4] == 2'b10 && PIX_O.valid);
    c_read: cover property (WB_ACK_O && !WB_WE_I);
endmodule

bind irbp_top irbp_chk u_chk (.REF_CLK, .SYS_RST, .WB_ADR_I, .WB_DAT_I,
    .WB_WE_I, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .PIX_I, .PIX_O,
    .SENSOR_HFLIP, .SENSOR_VFLIP);

// >>> dv/irbp_sensor.sv
// behavioural image sensor readout feeding the pipeline
`timescale 1ns/100ps

module irbp_sensor
    import irbp_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] w,
    input wire logic [15:0] h,
    input wire logic hflip,
    input wire logic vflip,
    input wire logic slow,
    input wire logic [11:0] salt,
    output irbp_pix_s pix,
    output logic busy
);
    int sx;
    int sy;
    initial begin
        pix = '0;
        busy = 1'b0;
    end

    // ****************************************
    // frame readout
    // ****************************************
    // one frame per go; slow mode leaves a dead cycle per pixel
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int y = 0; y < h; y++) begin
                for (int x = 0; x < w; x++) begin
                    sx = hflip ? w - 1 - x : x;
                    sy = vflip ? h - 1 - y : y;
                    pix <= '{1'b1, x == 0 && y == 0, x == w - 1,
                        x == w - 1 && y == h - 1,
                        12'(sx * 37 + sy * 311) + salt};
                    @(posedge clk);
                    if (slow) begin
                        pix.valid <= 1'b0;
                        pix.data <= ~pix.data;
                        @(posedge clk);
                    end
                end
            end
            // idle data is the last pixel inverted, or the last pixel again in slow mode
            pix.valid <= 1'b0;
            pix.data <= ~pix.data;
            busy <= 1'b0;
        end
    end
endmodule

// >>> dv/tb_irbp_top.sv
// self-checking bench for the region, flip, binning and pattern pipeline
`timescale 1ns/100ps

module tb_irbp_top
    import irbp_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [11:0] salt = 12'h000;
    logic [31:0] rdat;
    logic ack;
    logic hfo;
    logic vfo;
    logic busy;
    logic [15:0] lcnt;
    logic [15:0] lfst;
    irbp_pix_s pix;
    irbp_pix_s po;
    int err_total = 0;
    int n_compared = 0;
    int seed = 49;
    int pq[$];
    logic [31:0] rq[$];
    logic [12:0] ctl;
    int w;
    int h;
    int fc;
    logic [11:0] sv;
    int rx[2] = '{2, 9};
    int rw[2] = '{3, 4};
    int ry[2] = '{1, 5};
    int rh[2] = '{2, 3};
    logic [7:0] ma[8] = '{8'h40, 8'h44, 8'h50, 8'h54,
        8'h80, 8'h84, 8'h90, 8'h94};
    logic [31:0] md[8] = '{32'h0001_0002, 32'h0001_0009, 32'h0005_0002,
        32'h0005_0009, 32'h0002_0003, 32'h0007_0004, 32'h0003_0009,
        32'h0007_0007};

    always #2.5 clk = ~clk;

    irbp_top dut (
        .REF_CLK(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
        .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .PIX_I(pix), .PIX_O(po),
        .SENSOR_HFLIP(hfo), .SENSOR_VFLIP(vfo),
        .SENSOR_LINE_FIRST(lfst), .SENSOR_LINE_COUNT(lcnt)
    );
    irbp_sensor u_sen (
        .clk(clk), .go(go), .w(16'(w)), .h(16'(h)), .hflip(hfo),
        .vflip(vfo), .slow(slow), .salt(salt), .pix(pix), .busy(busy)
    );

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task final_report;
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // pixel value at a readout site, before binning
    function automatic int pval(int x, int y, int fr);
        int t;
        t = x * 273 + y * 585;
        case (ctl[9:8])
            2'd0: t = (37 * (ctl[1] ? w - 1 - x : x)
                + 311 * (ctl[2] ? h - 1 - y : y) + sv) & 4095;
            2'd1: t = x * 273;
            2'd2: t = y * 585;
            default: t = ((t > 4095 ? 4095 : t) + fr) & 4095;
        endcase
        return t > 4095 ? 4095 : t;
    endfunction

    // notes every output pixel of the coming frame, in order
    task automatic expect_frame(input int fr);
        int xs[$];
        int ys[$];
        int s;
        int hb;
        int vb;
        int k;
        hb = 1 << ctl[5:4];
        vb = 1 << ctl[7:6];
        // mirrored regions reach the pipeline in reverse scan order
        for (int r = 0; r < (ctl[0] ? 2 : 1); r++) begin
            k = ctl[2] ? 1 - r : r;
            for (int l = 0; l < (ctl[0] ? rh[k] : h); l++)
                ys.push_back((ctl[0] ? (ctl[2] ? h - ry[k] - rh[k] : ry[k])
                    : 0) + l);
        end
        for (int c = 0; c < (ctl[0] ? 2 : 1); c++) begin
            k = ctl[1] ? 1 - c : c;
            for (int p = 0; p < (ctl[0] ? rw[k] : w); p++)
                xs.push_back((ctl[0] ? (ctl[1] ? w - rx[k] - rw[k] : rx[k])
                    : 0) + p);
        end
        for (int j = 0; j < ys.size() / vb; j++)
            for (int i = 0; i < xs.size() / hb; i++) begin
                s = 0;
                for (int a = 0; a < vb * hb; a++)
                    s += pval(xs[i * hb + a % hb], ys[j * vb + a / hb], fr);
                s = s > 4095 ? 4095 : s;
                pq.push_back(ctl[12] ? s & 255 : s);
            end
    endtask

    // ****************************************
    // drivers
    // ****************************************
    task automatic reset_dut;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // classic single cycle; held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic wr,
        input logic [31:0] d, output logic [31:0] q);
        adr <= a;
        we <= wr;
        dat <= d;
        sel <= 4'hF;
        cyc <= 1'b1;
        stb <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        rq.push_back(e);
        wb(a, 1'b0, 32'h0000_0000, q);
    endtask

    // sets the mode while the sensor idles, then streams one frame
    task automatic run(input logic [12:0] c, input int fw, input int fh,
        input logic sl);
        logic [31:0] q;
        int n;
        ctl = c;
        w = fw;
        h = fh;
        slow <= sl;
        wr(8'h08, {16'(fh), 16'(fw)});
        wr(8'h00, 32'(c));
        wb(8'h10, 1'b0, 32'h0000_0000, q);
        fc = q[31:16];
        sv = 12'($random(seed));
        salt <= sv;
        expect_frame(fc);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy || n < 3);
        repeat (8) @(posedge clk);
        chk(pq.size(), 0);
    endtask

    // ****************************************
    // monitors
    // ****************************************
    // read answers against the notes of the driver
    always @(posedge clk) begin
        if (ack === 1'b1 && !we && rq.size() > 0)
            chk(rdat, rq.pop_front());
    end

    // every output beat takes the oldest note; no framing marks judged
    always @(posedge clk) begin
        if (po.valid === 1'b1) begin
            if (pq.size() == 0)
                chk(32'h0000_0001, 32'h0000_0000);
            else
                chk(32'(po.data), pq.pop_front());
        end
    end

    // hang guard, far beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        final_report();
    end

    initial begin
        logic [31:0] q;
        reset_dut();
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0404);
        rd(8'h58, 32'h0080_0100);
        rd(8'h94, 32'h0040_0040);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            wr(8'h08, {16'(6 - 2 * i), 16'h0010});
            wb(8'h10, 1'b0, 32'h0000_0000, q);
            chk(32'(q[1:0]), 32'(i * 2 + 1));
        end
        wr(8'h0C, 32'h0249_0111);
        run(13'h0000, 16, 8, 1'b1);
        run(13'h0006, 16, 8, 1'b0);
        run(13'h0106, 16, 8, 1'b0);
        run(13'h0206, 16, 8, 1'b1);
        run(13'h1300, 16, 8, 1'b0);
        q = fc;
        run(13'h1300, 16, 8, 1'b0);
        chk(32'(fc), q + 1);
        run(13'h0060, 256, 8, 1'b0);
        run(13'h0090, 128, 8, 1'b0);
        reset_dut();
        rd(8'h04, 32'h0000_0404);
        wr(8'h04, 32'h0000_0202);
        for (int i = 0; i < 8; i++)
            wr(ma[i], md[i]);
        run(13'h0001, 16, 8, 1'b0);
        chk(32'(lcnt < 16'h0008), 32'h0000_0001);
        chk(32'(lfst), 32'h0000_0001);
        run(13'h0007, 16, 8, 1'b0);
        rd(8'h44, 32'h0001_0009);
        final_report();
    end
endmodule
